/* core/icc_lru.sv */
// Shared constants and types, and the per-set least recently used tracker.
`timescale 1ns/1ps
package icc_pkg;
	localparam int ADDR_W = 32;
	localparam int WORD_W = 32;
	localparam int MEM_W = 64;
	localparam int CACHE_BYTES = 8192;
	localparam int WAYS = 4;
	localparam int LINE_BYTES = 32;
	localparam int SETS = CACHE_BYTES / (WAYS * LINE_BYTES);
	localparam int OFS_W = 5;
	localparam int IDX_W = 6;
	localparam int TAG_W = ADDR_W - IDX_W - OFS_W;
	localparam int WAY_W = 2;
	localparam int BEATS = LINE_BYTES * 8 / MEM_W;
	localparam int BEAT_W = 2;
	localparam int LINE_W = LINE_BYTES * 8;
	localparam int LINES = SETS * WAYS;
	localparam int LCNT_W = 8;
	localparam int SEG_W = 13;
	localparam int FLASH_SPAN_W = 19;
	localparam int DDR_SPAN_W = 30;
	localparam logic [ADDR_W-1:0] FLASH_BASE = 32'h6000_0000;
	localparam logic [ADDR_W-1:0] DDR_BASE = 32'ha000_0000;
	localparam logic [BEAT_W-1:0] LAST_BEAT_LINE = 2'h3;
	localparam logic [BEAT_W-1:0] LAST_BEAT_WORD = 2'h0;
	localparam logic [LCNT_W-1:0] LAST_LINE = 8'hff;
	localparam logic [OFS_W-1:0] LINE_OFS_ZERO = 5'h00;
	localparam logic [SEG_W-1:0] SEG_OFS_ZERO = 13'h0000;
	localparam logic [2:0] WORD_ALIGN_ZERO = 3'h0;

	typedef enum {ST_IDLE, ST_FILL, ST_BYPASS} icc_state_e;

	typedef struct packed {
		logic req;
		logic [ADDR_W-1:0] addr;
	} icc_fetch_s;

	typedef struct packed {
		logic valid;
		logic [WORD_W-1:0] data;
	} icc_reply_s;

	typedef struct packed {
		logic req;
		logic [ADDR_W-1:0] addr;
		logic [BEAT_W-1:0] last_beat;
		logic ddr;
	} icc_mem_s;
endpackage

module icc_lru #(
	parameter int SETS = 64,
	parameter int WAYS = 4,
	parameter int SET_W = $clog2(SETS),
	parameter int WAY_W = $clog2(WAYS)
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset_n,
	// Access report.
	input wire logic touch,
	input wire logic [SET_W-1:0] touch_set,
	input wire logic [WAY_W-1:0] touch_way,
	// Victim query.
	input wire logic [SET_W-1:0] look_set,
	output logic [WAY_W-1:0] victim_way
);
	logic [WAY_W-1:0] age_r [SETS][WAYS];

	if (WAYS != (1 << WAY_W)) begin : g_bad_ways
		$error("icc_lru needs a power of two number of ways.");
	end

	// ----------------------------------------
	// Age per way: touched way becomes youngest.
	// ----------------------------------------
	for (genvar s = 0; s < SETS; s++) begin : g_set
		for (genvar w = 0; w < WAYS; w++) begin : g_way
			always_ff @(posedge clk_sys) begin
				if (!reset_n) begin
					age_r[s][w] <= WAY_W'(w);
				end else if (touch && touch_set == SET_W'(s)) begin
					if (touch_way == WAY_W'(w)) begin
						age_r[s][w] <= '0;
					end else if (age_r[s][w] < age_r[s][touch_way]) begin
						age_r[s][w] <= age_r[s][w] + 1'b1;
					end
				end
			end
		end
	end

	// ----------------------------------------
	// Oldest way of the looked-up set.
	// ----------------------------------------
	always_comb begin
		victim_way = '0;
		for (int w = 0; w < WAYS; w++) begin
			if (age_r[look_set][w] == WAY_W'(WAYS - 1)) begin
				victim_way = WAY_W'(w);
			end
		end
	end
endmodule

/* core/icc_ctrl.sv */
// Instruction cache controller shared by the instruction and data code fetch ports.
`timescale 1ns/1ps
module icc_ctrl (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset_n,
	// Configuration.
	input wire logic cache_en,
	input wire logic lock_en,
	input wire logic [icc_pkg::ADDR_W-icc_pkg::SEG_W-1:0] lock_base,
	// Processor fetch ports.
	input wire icc_pkg::icc_fetch_s icode_req,
	input wire icc_pkg::icc_fetch_s dcode_req,
	output icc_pkg::icc_reply_s icode_rsp_r,
	output icc_pkg::icc_reply_s dcode_rsp_r,
	// Backing memory.
	output icc_pkg::icc_mem_s mem_cmd_r,
	input wire logic mem_rvalid,
	input wire logic [icc_pkg::MEM_W-1:0] mem_rdata
);
	localparam int AW = icc_pkg::ADDR_W;
	localparam int WAYS = icc_pkg::WAYS;
	localparam int SETS = icc_pkg::SETS;
	localparam int OFS_W = icc_pkg::OFS_W;
	localparam int IDX_W = icc_pkg::IDX_W;
	localparam int TAG_W = icc_pkg::TAG_W;
	localparam int WAY_W = icc_pkg::WAY_W;

	if (SETS * WAYS * icc_pkg::LINE_BYTES != icc_pkg::CACHE_BYTES || icc_pkg::BEATS != 4 ||
		SETS != (1 << IDX_W) || icc_pkg::LINES != (1 << icc_pkg::LCNT_W)) begin : g_bad_geometry
		$error("icc_ctrl geometry constants are inconsistent.");
	end

	icc_pkg::icc_state_e state_r;
	logic own_d_r;
	logic [AW-1:0] pend_addr_r;
	logic [IDX_W-1:0] fill_set_r;
	logic [WAY_W-1:0] fill_way_r;
	logic [TAG_W-1:0] fill_tag_r;
	logic [icc_pkg::BEAT_W-1:0] beat_r;
	logic preload_r;
	logic [icc_pkg::LCNT_W-1:0] line_cnt_r;
	logic lock_loaded_r;
	logic en_q_r;
	logic valid_r [WAYS][SETS];
	logic [TAG_W-1:0] tag_r [WAYS][SETS];
	logic [icc_pkg::LINE_W-1:0] data_r [WAYS][SETS];

	// ----------------------------------------
	// Port selection and address split.
	// ----------------------------------------
	wire pick_d = !icode_req.req && dcode_req.req;
	wire any_req = icode_req.req || dcode_req.req;
	wire [AW-1:0] sel_addr = pick_d ? dcode_req.addr : icode_req.addr;
	wire [IDX_W-1:0] sel_set = sel_addr[OFS_W+IDX_W-1:OFS_W];
	wire [TAG_W-1:0] sel_tag = sel_addr[AW-1:OFS_W+IDX_W];
	wire [2:0] sel_word = sel_addr[OFS_W-1:2];

	// ----------------------------------------
	// Mode decode.
	// ----------------------------------------
	wire cache_on = cache_en && en_q_r;
	wire invalidate = cache_en && !en_q_r;
	wire lock_mode = cache_on && lock_en;
	wire start_preload = lock_mode && !lock_loaded_r;
	wire in_flash = sel_addr[AW-1:icc_pkg::FLASH_SPAN_W] == icc_pkg::FLASH_BASE[AW-1:icc_pkg::FLASH_SPAN_W];
	// The DDR window is not aligned to its size, so the offset from its base is tested.
	wire [AW-1:0] ddr_ofs = sel_addr - icc_pkg::DDR_BASE;
	wire in_ddr = ddr_ofs[AW-1:icc_pkg::DDR_SPAN_W] == '0;
	wire in_region = in_flash || in_ddr;
	wire in_seg = sel_addr[AW-1:icc_pkg::SEG_W] == lock_base;
	wire use_cache = cache_on && in_region && (!lock_mode || in_seg);
	wire allocate = use_cache && !lock_mode;

	// ----------------------------------------
	// Tag compare across the four ways.
	// ----------------------------------------
	logic [WAYS-1:0] way_hit;
	logic [WAY_W-1:0] hit_way;
	logic [WAYS-1:0] way_free;
	logic [WAY_W-1:0] lru_way;
	logic [WAY_W-1:0] victim;

	for (genvar w = 0; w < WAYS; w++) begin : g_cmp
		assign way_hit[w] = valid_r[w][sel_set] && tag_r[w][sel_set] == sel_tag;
		assign way_free[w] = !valid_r[w][sel_set];
	end

	always_comb begin
		hit_way = '0;
		victim = lru_way;
		for (int w = WAYS - 1; w >= 0; w--) begin
			if (way_hit[w]) begin
				hit_way = WAY_W'(w);
			end
			if (way_free[w]) begin
				victim = WAY_W'(w);
			end
		end
	end

	wire hit = use_cache && |way_hit;
	wire [icc_pkg::WORD_W-1:0] hit_word = data_r[hit_way][sel_set][sel_word*icc_pkg::WORD_W +: icc_pkg::WORD_W];
	wire take = state_r == icc_pkg::ST_IDLE && !start_preload && any_req;
	wire fill_wr = state_r == icc_pkg::ST_FILL && mem_rvalid;
	wire fill_last = fill_wr && beat_r == icc_pkg::LAST_BEAT_LINE;
	wire [icc_pkg::LCNT_W-1:0] next_line = line_cnt_r + 1'b1;
	wire [AW-1:0] seg_base = {lock_base, icc_pkg::SEG_OFS_ZERO};
	wire [AW-1:0] seg_ddr_ofs = seg_base - icc_pkg::DDR_BASE;
	wire seg_ddr = seg_ddr_ofs[AW-1:icc_pkg::DDR_SPAN_W] == '0;
	wire [icc_pkg::WORD_W-1:0] byp_word = pend_addr_r[2] ? mem_rdata[icc_pkg::MEM_W-1:icc_pkg::WORD_W] :
		mem_rdata[icc_pkg::WORD_W-1:0];
	wire reply_hit = take && hit;
	wire reply_byp = state_r == icc_pkg::ST_BYPASS && mem_rvalid;
	wire [icc_pkg::WORD_W-1:0] reply_data = reply_byp ? byp_word : hit_word;
	wire reply_d = reply_byp ? own_d_r : pick_d;
	wire [AW-1:0] preload_addr = seg_base | {{(AW-icc_pkg::LCNT_W-OFS_W){1'b0}}, next_line, icc_pkg::LINE_OFS_ZERO};

	icc_lru #(
		.SETS(SETS),
		.WAYS(WAYS)
	) u_lru (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.touch(reply_hit),
		.touch_set(sel_set),
		.touch_way(hit_way),
		.look_set(sel_set),
		.victim_way(lru_way)
	);

	// ----------------------------------------
	// Replies to the two ports.
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			icode_rsp_r <= '0;
			dcode_rsp_r <= '0;
		end else begin
			icode_rsp_r <= '{valid: (reply_hit || reply_byp) && !reply_d, data: reply_data};
			dcode_rsp_r <= '{valid: (reply_hit || reply_byp) && reply_d, data: reply_data};
		end
	end

	// ----------------------------------------
	// Control sequence.
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_r <= icc_pkg::ST_IDLE;
			own_d_r <= 1'b0;
			pend_addr_r <= '0;
			fill_set_r <= '0;
			fill_way_r <= '0;
			fill_tag_r <= '0;
			beat_r <= '0;
			preload_r <= 1'b0;
			line_cnt_r <= '0;
			lock_loaded_r <= 1'b0;
			en_q_r <= 1'b0;
			mem_cmd_r <= '0;
		end else begin
			en_q_r <= cache_en;
			mem_cmd_r.req <= 1'b0;
			case (state_r)
				icc_pkg::ST_IDLE: begin
					beat_r <= '0;
					if (!lock_mode) begin
						lock_loaded_r <= 1'b0;
					end
					if (start_preload) begin
						preload_r <= 1'b1;
						line_cnt_r <= '0;
						fill_set_r <= '0;
						fill_way_r <= '0;
						fill_tag_r <= seg_base[AW-1:OFS_W+IDX_W];
						mem_cmd_r <= '{req: 1'b1, addr: seg_base, last_beat: icc_pkg::LAST_BEAT_LINE,
							ddr: seg_ddr};
						state_r <= icc_pkg::ST_FILL;
					end else if (any_req && !hit) begin
						own_d_r <= pick_d;
						pend_addr_r <= sel_addr;
						if (allocate) begin
							fill_set_r <= sel_set;
							fill_way_r <= victim;
							fill_tag_r <= sel_tag;
							mem_cmd_r <= '{req: 1'b1, addr: {sel_addr[AW-1:OFS_W], icc_pkg::LINE_OFS_ZERO},
								last_beat: icc_pkg::LAST_BEAT_LINE, ddr: in_ddr};
							state_r <= icc_pkg::ST_FILL;
						end else begin
							mem_cmd_r <= '{req: 1'b1, addr: {sel_addr[AW-1:3], icc_pkg::WORD_ALIGN_ZERO},
								last_beat: icc_pkg::LAST_BEAT_WORD, ddr: in_ddr};
							state_r <= icc_pkg::ST_BYPASS;
						end
					end
				end
				icc_pkg::ST_FILL: begin
					if (fill_wr) begin
						beat_r <= beat_r + 1'b1;
					end
					if (fill_last) begin
						if (preload_r && line_cnt_r != icc_pkg::LAST_LINE) begin
							line_cnt_r <= next_line;
							fill_set_r <= next_line[IDX_W-1:0];
							fill_way_r <= next_line[icc_pkg::LCNT_W-1:IDX_W];
							fill_tag_r <= preload_addr[AW-1:OFS_W+IDX_W];
							mem_cmd_r <= '{req: 1'b1, addr: preload_addr, last_beat: icc_pkg::LAST_BEAT_LINE,
								ddr: mem_cmd_r.ddr};
						end else begin
							lock_loaded_r <= preload_r;
							preload_r <= 1'b0;
							state_r <= icc_pkg::ST_IDLE;
						end
					end
				end
				icc_pkg::ST_BYPASS: begin
					if (mem_rvalid) begin
						state_r <= icc_pkg::ST_IDLE;
					end
				end
				default: begin
					state_r <= icc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Line storage: tags, valid bits and data.
	// ----------------------------------------
	for (genvar w = 0; w < WAYS; w++) begin : g_way
		for (genvar s = 0; s < SETS; s++) begin : g_set
			wire sel_line = fill_way_r == WAY_W'(w) && fill_set_r == IDX_W'(s);
			always_ff @(posedge clk_sys) begin
				if (!reset_n) begin
					valid_r[w][s] <= 1'b0;
					tag_r[w][s] <= '0;
				end else if (invalidate) begin
					valid_r[w][s] <= 1'b0;
				end else if (fill_last && sel_line) begin
					valid_r[w][s] <= 1'b1;
					tag_r[w][s] <= fill_tag_r;
				end
			end
			always_ff @(posedge clk_sys) begin
				if (fill_wr && sel_line) begin
					data_r[w][s][beat_r*icc_pkg::MEM_W +: icc_pkg::MEM_W] <= mem_rdata;
				end
			end
		end
	end
endmodule

/* dv/icc_mem_model.sv */
// Behavioural backing memory answering commands beat by beat.
`timescale 1ns/1ps
module icc_mem_model (
	// Clock and command.
	input wire logic clk_sys,
	input wire icc_pkg::icc_mem_s cmd,
	input wire logic slow,
	// Read data.
	output logic rvalid,
	output logic [63:0] rdata
);
	logic [31:0] a;
	logic [2:0] k;
	function automatic logic [31:0] wd(input logic [31:0] x);
		return x ^ 32'hc3a5_0f96;
	endfunction
	initial begin
		rvalid = 1'b0;
		rdata = 64'h0;
		forever begin
			@(posedge clk_sys);
			#1;
			rvalid = 1'b0;
			rdata = ~rdata;
			if (cmd.req) begin
				a = cmd.addr;
				for (k = 3'h0; k <= {1'b0, cmd.last_beat}; k++) begin
					@(posedge clk_sys);
					#1;
					if (slow && k[0]) begin
						rvalid = 1'b0;
						rdata = ~rdata;
						@(posedge clk_sys);
						#1;
					end
					rvalid = 1'b1;
					rdata = {wd(a + 32'h4), wd(a)};
					a = a + 32'h8;
				end
			end
		end
	end
endmodule

/* dv/icc_ctrl_props.sv */
// Concurrent checks on the cache controller ports.
`timescale 1ns/1ps
module icc_ctrl_props (
	// Clock, reset and configuration.
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic cache_en,
	input wire logic lock_en,
	input wire logic [icc_pkg::ADDR_W-icc_pkg::SEG_W-1:0] lock_base,
	// Fetch ports.
	input wire icc_pkg::icc_fetch_s icode_req,
	input wire icc_pkg::icc_fetch_s dcode_req,
	input wire icc_pkg::icc_reply_s icode_rsp_r,
	input wire icc_pkg::icc_reply_s dcode_rsp_r,
	// Backing memory.
	input wire icc_pkg::icc_mem_s mem_cmd_r,
	input wire logic mem_rvalid,
	input wire logic [icc_pkg::MEM_W-1:0] mem_rdata
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	logic [2:0] left_r;
	logic line_r;
	logic [8:0] lcnt_r;
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			left_r <= 3'h0;
			line_r <= 1'b0;
			lcnt_r <= 9'h0;
		end else begin
			if (mem_cmd_r.req) begin
				left_r <= {1'b0, mem_cmd_r.last_beat} + 3'h1;
				line_r <= mem_cmd_r.last_beat == 2'h3;
			end else if (mem_rvalid && left_r != 3'h0) begin
				left_r <= left_r - 3'h1;
			end
			if (!lock_en) begin
				lcnt_r <= 9'h0;
			end else if (mem_cmd_r.req && mem_cmd_r.last_beat == 2'h3) begin
				lcnt_r <= lcnt_r + 9'h1;
			end
		end
	end
	sequence s_last_beat;
		mem_rvalid && left_r == 3'h1;
	endsequence
	sequence s_reply;
		icode_rsp_r.valid || dcode_rsp_r.valid;
	endsequence
	a_icode_reply: assert property (icode_rsp_r.valid |-> $past(icode_req.req))
		else $error("icode reply without request");
	a_dcode_reply: assert property (dcode_rsp_r.valid |-> $past(dcode_req.req))
		else $error("dcode reply without request");
	a_cmd_shape: assert property (mem_cmd_r.req |-> (mem_cmd_r.last_beat == 2'h3 && mem_cmd_r.addr[4:0] == 5'h0)
		|| (mem_cmd_r.last_beat == 2'h0 && mem_cmd_r.addr[2:0] == 3'h0))
		else $error("bad command shape");
	a_off_word_only: assert property (mem_cmd_r.req && !$past(cache_en) && !$past(cache_en, 2)
		|-> mem_cmd_r.last_beat == 2'h0)
		else $error("line fill while disabled");
	a_ddr_flag: assert property (mem_cmd_r.req |-> mem_cmd_r.ddr == (mem_cmd_r.addr >= icc_pkg::DDR_BASE
		&& mem_cmd_r.addr < 32'he000_0000))
		else $error("wrong region flag");
	a_fill_then_hit: assert property (s_last_beat ##0 (line_r && !lock_en) |-> ##2 s_reply)
		else $error("no reply after fill");
	a_bypass_reply: assert property (s_last_beat ##0 !line_r |=> s_reply)
		else $error("no reply after bypass");
	a_one_outstanding: assert property (mem_cmd_r.req |-> left_r == 3'h0)
		else $error("command while busy");
	a_cmd_pulse: assert property (mem_cmd_r.req |=> !mem_cmd_r.req)
		else $error("command longer than a cycle");
	a_lock_bound: assert property (mem_cmd_r.req && mem_cmd_r.last_beat == 2'h3 && lock_en
		|-> lcnt_r < 9'h100)
		else $error("locked lines replaced");
endmodule

/* dv/test_instruction_cache_controller.sv */
// Self-checking bench for the instruction cache controller.
`timescale 1ns/1ps
module test_instruction_cache_controller;
	localparam logic [31:0] F = icc_pkg::FLASH_BASE;
	localparam logic [31:0] D = icc_pkg::DDR_BASE;
	logic clk_sys = 1'b0;
	logic reset_n, cache_en, lock_en, slow, dd, mem_rvalid;
	logic [18:0] lock_base;
	icc_pkg::icc_fetch_s iq, dq;
	icc_pkg::icc_reply_s irs, drs, rs;
	icc_pkg::icc_mem_s mc;
	logic [63:0] mem_rdata;
	logic [31:0] seed, dw, ca, a, r, nc, cy;
	logic [1:0] lb;
	int num_errors = 0;
	int checks = 0;
	int i;
	always #2 clk_sys = ~clk_sys;
	icc_ctrl dut (.clk_sys(clk_sys), .reset_n(reset_n), .cache_en(cache_en), .lock_en(lock_en),
		.lock_base(lock_base), .icode_req(iq), .dcode_req(dq), .icode_rsp_r(irs), .dcode_rsp_r(drs),
		.mem_cmd_r(mc), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
	icc_mem_model mem (.clk_sys(clk_sys), .cmd(mc), .slow(slow), .rvalid(mem_rvalid), .rdata(mem_rdata));
	function automatic logic [31:0] ew(input logic [31:0] x);
		return {x[31:2], 2'h0} ^ 32'hc3a5_0f96;
	endfunction
	task automatic conclude();
		if (num_errors == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic idle();
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	task automatic fetch(input logic p, input logic [31:0] x);
		nc = 32'h0;
		if (p) dq = '{1'b1, x};
		else iq = '{1'b1, x};
		for (cy = 32'h1; cy < 32'hbb8; cy++) begin
			@(posedge clk_sys);
			#1;
			if (mc.req) begin
				nc++;
				lb = mc.last_beat;
				ca = mc.addr;
				dd = mc.ddr;
			end
			rs = p ? drs : irs;
			if (rs.valid === 1'b1) break;
		end
		dw = rs.data;
		if (p) dq.req = 1'b0;
		else iq.req = 1'b0;
		if (cy == 32'hbb8) begin
			num_errors++;
			conclude();
		end
		@(posedge clk_sys);
		#1;
	endtask
	// Kind k: 0 hit, 1 line fill, 2 bypass.
	task automatic go(input logic p, input logic [31:0] x, input logic [1:0] k);
		fetch(p, x);
		chk(dw, ew(x));
		chk(nc, {31'h0, k != 2'h0});
		if (k == 2'h0) chk(cy, 32'h1);
		if (k == 2'h1) chk({25'h0, lb, ca[4:0]}, 32'h60);
		if (k == 2'h2) chk({27'h0, lb, ca[2:0]}, 32'h0);
		if (k != 2'h0) chk({31'h0, dd}, {31'h0, x >= D && x < 32'he000_0000});
	endtask
	initial begin
		seed = 32'h6353eee2;
		reset_n = 1'b0;
		cache_en = 1'b0;
		lock_en = 1'b0;
		lock_base = 19'h0;
		slow = 1'b0;
		iq = '0;
		dq = '0;
		repeat (10) @(posedge clk_sys);
		#1;
		chk({29'h0, mc.req, irs.valid, drs.valid}, 32'h0);
		reset_n = 1'b1;
		cache_en = 1'b1;
		idle();
		go(1'b0, F + 32'h44, 2'h1);
		go(1'b0, F + 32'h48, 2'h0);
		go(1'b1, F + 32'h5c, 2'h0);
		go(1'b1, D + 32'h100, 2'h1);
		go(1'b0, D + 32'h104, 2'h0);
		iq = '{1'b1, F + 32'h48};
		dq = '{1'b1, D + 32'h104};
		@(posedge clk_sys);
		#1;
		chk({30'h0, irs.valid, drs.valid}, 32'h2);
		chk(irs.data, ew(F + 32'h48));
		iq.req = 1'b0;
		@(posedge clk_sys);
		#1;
		chk({30'h0, irs.valid, drs.valid}, 32'h1);
		chk(drs.data, ew(D + 32'h104));
		dq.req = 1'b0;
		idle();
		go(1'b1, 32'hdfff_ffe4, 2'h1);
		go(1'b0, 32'h9000_0008, 2'h2);
		go(1'b0, 32'h2000_0010, 2'h2);
		for (i = 0; i < 8; i++) go(i[0], F + {19'h0, i[1:0], 11'h0}, {1'b0, i < 4});
		go(1'b0, F, 2'h0);
		go(1'b0, F + 32'h2000, 2'h1);
		go(1'b0, F + 32'h1000, 2'h0);
		go(1'b0, F + 32'h800, 2'h1);
		slow = 1'b1;
		repeat (40) begin
			r = $random(seed);
			a = F + {13'h0, r[18:2], 2'h0};
			fetch(r[31], a);
			chk(dw, ew(a));
			go(~r[31], a, 2'h0);
		end
		slow = 1'b0;
		cache_en = 1'b0;
		idle();
		go(1'b0, F + 32'h48, 2'h2);
		go(1'b1, F + 32'h48, 2'h2);
		cache_en = 1'b1;
		idle();
		go(1'b0, F + 32'h48, 2'h1);
		lock_base = F[31:13] + 19'h1;
		lock_en = 1'b1;
		fetch(1'b0, F + 32'h2010);
		chk(nc, 32'h100);
		chk(dw, ew(F + 32'h2010));
		go(1'b1, F + 32'h3ffc, 2'h0);
		go(1'b0, F + 32'h48, 2'h2);
		for (i = 0; i < 3; i++) go(1'b0, D + {19'h0, i[1:0], 11'h0}, 2'h2);
		go(1'b0, F + 32'h2000, 2'h0);
		conclude();
	end
endmodule
bind icc_ctrl icc_ctrl_props u_props (.clk_sys(clk_sys), .reset_n(reset_n), .cache_en(cache_en),
	.lock_en(lock_en), .lock_base(lock_base), .icode_req(icode_req), .dcode_req(dcode_req),
	.icode_rsp_r(icode_rsp_r), .dcode_rsp_r(dcode_rsp_r), .mem_cmd_r(mem_cmd_r),
	.mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
